// ### verification/ccfg_i2c_host.sv
// Purpose: Serial bus controller model for the configuration target.
// Assumes: Open-drain data with pull-up; clock stays high between frames.
// Notes: Phases span several hclk because the target oversamples the lines.
`timescale 1ns/1ps
module ccfg_i2c_host (
  input wire hclk,
  input wire sda_line,
  output reg scl,
  output reg sda_low
);
  integer slow = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wait_n(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic xfer_bit(input logic b, output logic r);
    begin
      sda_low <= ~b;
      wait_n(4 + slow);
      scl <= 1'b1;
      wait_n(4 + slow);
      r = sda_line;
      scl <= 1'b0;
      wait_n(2);
    end
  endtask
  task automatic start_cond;
    begin
      sda_low <= 1'b0;
      wait_n(4);
      scl <= 1'b1;
      wait_n(4);
      sda_low <= 1'b1;
      wait_n(4);
      scl <= 1'b0;
      wait_n(2);
    end
  endtask
  task automatic stop_cond;
    begin
      sda_low <= 1'b1;
      wait_n(4);
      scl <= 1'b1;
      wait_n(4);
      sda_low <= 1'b0;
      wait_n(4);
    end
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
    end
  endtask
  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i--) begin
        xfer_bit(1'b1, r);
        d[i] = r;
      end
      xfer_bit(~ack_it, r);
    end
  endtask
endmodule

// ### verification/ccfg_monitor.sv
// Purpose: Port checker for the clock configuration block.
// Assumes: Bound to ccfg_top from the bench top file.
// Notes: Outputs load one edge after reset release, so value checks wait for that edge.
`timescale 1ns/1ps
module ccfg_monitor (
  input wire hclk,
  input wire hresetn,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [5:0] output_enable_bit,
  input wire [5:0] output_style_bit,
  input wire pll_skip_bit,
  input wire [8:0] feedback_divider,
  input wire [6:0] output_divider,
  input wire [2:0] input_divider,
  input wire [1:0] input_prescaler_code,
  input wire [1:0] charge_pump_range
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_fb_even: assert property ($past(hresetn) |-> !feedback_divider[0])
    else $error("feedback divider odd");
  a_ps_code: assert property ($past(hresetn) |-> input_prescaler_code != 2'h3)
    else $error("prescaler code out of set");
  a_in_div: assert property ($past(hresetn) |-> input_divider inside {3'h1, 3'h2, 3'h4, 3'h5})
    else $error("input divider out of set");
  a_out_div: assert property ($past(hresetn) |-> output_divider >= 7'h02 && output_divider <= 7'h7e &&
    (output_divider <= 7'h05 || !output_divider[0])) else $error("output divider out of range");
  a_reset_dflt: assert property ($rose(hresetn) |-> ##1 feedback_divider == 9'h064 &&
    output_divider == 7'h04 && output_enable_bit == 6'h3f && output_style_bit == 6'h3f && !pll_skip_bit &&
    charge_pump_range == 2'h2 && input_prescaler_code == 2'h2) else $error("defaults wrong after reset");
  // A data change while the clock is high would look like a start or stop.
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_sda_hold: assert property ($rose(scl_in) |=> $stable(sda_oe_n) [*3])
    else $error("data drive moved after clock rise");
  a_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
endmodule

// ### verification/tb_clock_synth_config_slave.sv
// Purpose: Self-checking bench for the clock configuration block.
// Assumes: The controller model owns the serial clock; data has a pull-up.
// Notes: Random sets come from a fixed-seed LFSR; divider corner codes come from a table.
`timescale 1ns/1ps
module tb_clock_synth_config_slave;
  reg hclk, hresetn, hsel, hwrite, addr_select, ack, ctl;
  reg [1:0] htrans, fsel;
  reg [2:0] hsize;
  reg [31:0] haddr, hwdata, rnd, rd;
  reg [7:0] m, nb, cfg, sty, en, bt, ptr;
  reg [7:0] bq [0:3];
  reg [55:0] ntabv = {7'h04, 7'h7f, 7'h06, 7'h05, 7'h03, 7'h02, 7'h01, 7'h00};
  wire hreadyout, hresp, sda_out, sda_oe_n, scl, sda_low, skp;
  wire [31:0] hrdata;
  wire [5:0] oe, st;
  wire [8:0] fbd;
  wire [6:0] odv;
  wire [2:0] idv;
  wire [1:0] psc, cpr;
  wire sda_line = ~sda_low & (sda_oe_n | sda_out);
  integer num_errors = 0, n_tests = 0, i, k;
  ccfg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_select(addr_select),
    .freq_set_select(fsel), .output_enable_bit(oe), .output_style_bit(st), .pll_skip_bit(skp),
    .feedback_divider(fbd), .output_divider(odv), .input_divider(idv), .input_prescaler_code(psc),
    .charge_pump_range(cpr));
  ccfg_i2c_host host (.hclk(hclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  function [6:0] ndec(input [6:0] c);
    ndec = (c < 7'h03) ? 7'h02 : ((c < 7'h06) ? c : {c[6:1], 1'b0});
  endfunction
  function [2:0] pdec(input [1:0] c);
    pdec = (c == 2'h3) ? 3'h5 : (3'h1 << c);
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests++;
      if (g !== e) begin
        num_errors++;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task wait_rdy;
    begin
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (hreadyout !== 1'b1 && k < 40);
      if (hreadyout !== 1'b1) begin
        num_errors++;
        $display("[ERR] hready exp 1 got %b", hreadyout);
        print_verdict;
      end
    end
  endtask
  task ahb(input logic wr, input [31:0] a, input [31:0] wd);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
      chk("hresp", 0, hresp);
    end
  endtask
  task i2c_wr(input [7:0] p, input integer cnt);
    integer j;
    begin
      host.start_cond;
      host.send_byte({6'h37, addr_select, 1'b0}, ack);
      chk("addr ack", 1, ack);
      host.send_byte(p, ack);
      chk("ptr ack", 1, ack);
      for (j = 0; j < cnt; j++) host.send_byte(bq[j], ack);
      chk("last data ack", 1, ack);
      host.stop_cond;
    end
  endtask
  task i2c_rd(input [7:0] p);
    integer j;
    begin
      host.start_cond;
      host.send_byte({6'h37, addr_select, 1'b0}, ack);
      host.send_byte(p, ack);
      host.start_cond;
      host.send_byte({6'h37, addr_select, 1'b1}, ack);
      chk("read addr ack", 1, ack);
      for (j = 0; j < 4; j++) begin
        host.recv_byte(j < 3, bt);
        chk("read byte", bq[j], bt);
      end
      // A wrongly resumed drive shows two edges after the fall, so look a little later.
      repeat (3) @(posedge hclk);
      chk("released after nack", 1, sda_oe_n);
      host.stop_cond;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; addr_select = 1'b0; fsel = 2'h0; rnd = 32'h843dcc4f;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("fb default", 9'h064, fbd);
    chk("oe default", 6'h3f, oe);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped read", 32'h0, rd);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      host.slow = i[0] ? 3 : 0;
      fsel <= rnd[1:0];
      addr_select <= rnd[2];
      ctl = rnd[3];
      ptr = {4'h0, rnd[1:0], 2'h0};
      m = 8'h08 + rnd[10:4] % 8'h76;
      nb = {(i < 7) ? ntabv[7 * i +: 7] : rnd[18:12], rnd[11]};
      // Pump code follows the divider so the model never asks for an unstable loop.
      cfg = {rnd[20:19], rnd[22:21], (m < 8'h18) ? 2'h0 : ((m < 8'h32) ? 2'h1 : 2'h2), rnd[24:23]};
      sty = rnd[31:24];
      en = rnd[30:23];
      ahb(1'b1, 32'h0, {31'h0, ctl});
      bq[0] = m; bq[1] = nb; bq[2] = cfg; bq[3] = sty;
      i2c_wr(ptr, 4);
      bq[0] = en;
      i2c_wr(8'h10 + {6'h0, rnd[1:0]}, 1);
      repeat (4) @(posedge hclk);
      chk("feedback", {m, 1'b0}, fbd);
      chk("out div", ndec(nb[7:1]), odv);
      chk("in div", ctl ? pdec(cfg[7:6]) : 3'h1, idv);
      chk("prescale", cfg[5] ? 2'h2 : cfg[5:4], psc);
      chk("pump", cfg[3:2], cpr);
      chk("skip", nb[0], skp);
      chk("style", sty[5:0], st);
      chk("enable", {en[7:5], en[3:1]}, oe);
      ahb(1'b0, 32'h4, 32'h0);
      chk("status select", rnd[1:0], rd[5:4]);
      ahb(1'b0, 32'h8, 32'h0);
      chk("dec0", {16'h0, m, 1'b0, ndec(nb[7:1])}, rd);
      ahb(1'b0, 32'hc, 32'h0);
      chk("dec1", {8'h0, en[7:5], en[3:1], sty[5:0], 1'b0, nb[0], cfg[3:2], cfg[5] ? 2'h2 : cfg[5:4],
        ctl ? pdec(cfg[7:6]) : 3'h1, 3'h0}, rd);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl", {31'h0, ctl}, rd);
      bq[0] = m; bq[1] = nb; bq[2] = cfg & 8'hfc; bq[3] = sty & 8'h3f;
      i2c_rd(ptr);
      $display("test %0d done", i);
    end
    host.start_cond;
    host.send_byte({6'h37, ~addr_select, 1'b0}, ack);
    chk("foreign addr ack", 0, ack);
    host.send_byte(ptr, ack);
    host.send_byte(8'h00, ack);
    chk("foreign data ack", 0, ack);
    host.stop_cond;
    repeat (4) @(posedge hclk);
    chk("foreign write ignored", {m, 1'b0}, fbd);
    $display("test foreign address done");
    print_verdict;
  end
endmodule
bind ccfg_top ccfg_monitor mon (.hclk(hclk), .hresetn(hresetn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .output_enable_bit(output_enable_bit), .output_style_bit(output_style_bit),
  .pll_skip_bit(pll_skip_bit), .feedback_divider(feedback_divider), .output_divider(output_divider),
  .input_divider(input_divider), .input_prescaler_code(input_prescaler_code),
  .charge_pump_range(charge_pump_range));

// ### verilog/ccfg_ahb_regs.v
// Purpose: AHB-Lite slave for control and status of the configuration block.
// Assumes: Single word transfers; one slave so hready is its own hreadyout.
// Notes: Zero wait states; unmapped offsets read zero and ignore writes.
`timescale 1ns/1ps
`include "ccfg_regs.vh"
module ccfg_ahb_regs (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] stat_in,
  input wire [31:0] dec0_in,
  input wire [31:0] dec1_in,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg clk_sel_q
);
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire take = hsel & htrans[1] & hready;
  wire ctrl_wr = wr_pend_q & (wr_addr_q == `CCFG_AHB_CTRL);
  reg [31:0] rd_d;
  always @* begin
    case (haddr[7:0])
      `CCFG_AHB_CTRL: rd_d = {31'h0, ctrl_wr ? hwdata[0] : clk_sel_q};
      `CCFG_AHB_STATUS: rd_d = stat_in;
      `CCFG_AHB_DEC0: rd_d = dec0_in;
      `CCFG_AHB_DEC1: rd_d = dec1_in;
      default: rd_d = 32'h0;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      clk_sel_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ctrl_wr) begin
        clk_sel_q <= hwdata[0];
      end
      wr_pend_q <= take & hwrite;
      if (take) begin
        wr_addr_q <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        hrdata <= rd_d;
      end
    end
  end
endmodule

// ### verilog/ccfg_div_decode.v
// Purpose: Decodes one stored divider code set into divider values.
// Assumes: Codes come from the selected configuration set.
// Notes: Purely combinational; the top registers the results.
`timescale 1ns/1ps
`include "ccfg_regs.vh"
module ccfg_div_decode (
  input wire clk_sel,
  input wire [7:0] m_code,
  input wire [6:0] n_code,
  input wire [1:0] p_code,
  input wire [1:0] ps_code,
  output reg [8:0] fb_div,
  output reg [6:0] out_div,
  output reg [2:0] in_div,
  output reg [1:0] ps_mode
);
  always @* begin
    fb_div = {m_code, 1'b0}; // RL8
    if (n_code <= 7'h02) begin
      out_div = 7'h02; // RL10
    end else if (n_code <= 7'h05) begin
      out_div = n_code; // RL10
    end else begin
      out_div = {n_code[6:1], 1'b0}; // RL10
    end
    // The crystal path has no pre-divider, so its code is ignored.
    if (!clk_sel) begin
      in_div = 3'h1; // RL9
    end else begin
      case (p_code)
        2'h0: in_div = 3'h1;
        2'h1: in_div = 3'h2;
        2'h2: in_div = 3'h4;
        default: in_div = 3'h5;
      endcase
    end
    if (ps_code[1]) begin
      ps_mode = `CCFG_PS_X2; // RL9
    end else if (ps_code[0]) begin
      ps_mode = `CCFG_PS_HALF;
    end else begin
      ps_mode = `CCFG_PS_X1;
    end
  end
endmodule

// ### verilog/ccfg_regs.vh
// Purpose: Shared constants of the clock synthesiser configuration block.
// Assumes: Included by bare name from every design file.
// Notes: Byte positions of the serial bank and bus register offsets.
`ifndef CCFG_REGS_VH
`define CCFG_REGS_VH
`define CCFG_TARGET_ADDR_HI 6'h37
`define CCFG_BANK_SIZE 24
`define CCFG_BANK_LAST 8'h17
`define CCFG_SET_STRIDE 4
`define CCFG_OFS_M 0
`define CCFG_OFS_N 1
`define CCFG_OFS_CFG 2
`define CCFG_OFS_STYLE 3
`define CCFG_OFS_OE 16
`define CCFG_FIRST_UNUSED 20
`define CCFG_DEF_M 8'h32
`define CCFG_DEF_N 8'h08
`define CCFG_DEF_CFG 8'h28
`define CCFG_DEF_STYLE 8'h3f
`define CCFG_DEF_OE 8'hee
`define CCFG_MASK_CFG 8'hfc
`define CCFG_MASK_STYLE 8'h3f
`define CCFG_MASK_OE 8'hee
`define CCFG_PS_X1 2'h0
`define CCFG_PS_HALF 2'h1
`define CCFG_PS_X2 2'h2
`define CCFG_AHB_CTRL 8'h00
`define CCFG_AHB_STATUS 8'h04
`define CCFG_AHB_DEC0 8'h08
`define CCFG_AHB_DEC1 8'h0c
`endif

// ### verilog/ccfg_top.v
// Purpose: Configuration logic of a six-output clock synthesiser.
// Assumes: Serial lines and select pins are synchronous to hclk.
// Notes: Serial lines are sampled on hclk, so hclk must be far above the bit rate.
// Operation
// RL1: Target address fixed, low bit from pin.
// RL2: Write: address, pointer, data bytes, each acknowledged.
// RL3: Read: pointer write, repeated start, read bytes.
// RL4: First byte after address loads pointer.
// RL5: Pointer increments per byte; MSB first.
// RL6: Stop after any byte keeps earlier bytes.
// RL7: Controller should stop after byte 23.
// RL8: Feedback divider even; bit zero not stored.
// RL9: Pre-divider and prescaler code decoding.
// RL10: Output divider code decoding to values.
// RL11: Controller pairs pump range with divider.
// RL12: Select pins choose one of four sets.
// RL13: Frequency follows pins and serial writes.
// RL14: Output style and state stay writable.
// RL15: All sets load factory defaults at reset.
// RL16: Enable bit zero means high impedance.
// RL17: Style bit one selects differential low-swing.
// RL18: Skip bit one bypasses the PLL.
// RL19: Acknowledge only own address, ignore others.
// RL20: Stop driving on read not-acknowledge.
`timescale 1ns/1ps
`include "ccfg_regs.vh"
module ccfg_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire addr_select,
  input wire [1:0] freq_set_select,
  output reg [5:0] output_enable_bit,
  output reg [5:0] output_style_bit,
  output reg pll_skip_bit,
  output reg [8:0] feedback_divider,
  output reg [6:0] output_divider,
  output reg [2:0] input_divider,
  output reg [1:0] input_prescaler_code,
  output reg [1:0] charge_pump_range
);
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_AACK = 4'h2;
  localparam [3:0] S_PTR = 4'h3;
  localparam [3:0] S_PACK = 4'h4;
  localparam [3:0] S_WDATA = 4'h5;
  localparam [3:0] S_WACK = 4'h6;
  localparam [3:0] S_RDATA = 4'h7;
  localparam [3:0] S_RACK = 4'h8;
  localparam [3:0] S_IGNORE = 4'h9;

  function [7:0] def_byte;
    input integer idx;
    begin
      if (idx >= `CCFG_FIRST_UNUSED) begin
        def_byte = 8'h00;
      end else if (idx >= `CCFG_OFS_OE) begin
        def_byte = `CCFG_DEF_OE;
      end else begin
        case (idx % `CCFG_SET_STRIDE)
          `CCFG_OFS_M: def_byte = `CCFG_DEF_M;
          `CCFG_OFS_N: def_byte = `CCFG_DEF_N;
          `CCFG_OFS_CFG: def_byte = `CCFG_DEF_CFG;
          default: def_byte = `CCFG_DEF_STYLE;
        endcase
      end
    end
  endfunction

  function [7:0] wmask;
    input integer idx;
    begin
      if (idx >= `CCFG_FIRST_UNUSED) begin
        wmask = 8'h00;
      end else if (idx >= `CCFG_OFS_OE) begin
        wmask = `CCFG_MASK_OE;
      end else begin
        case (idx % `CCFG_SET_STRIDE)
          `CCFG_OFS_CFG: wmask = `CCFG_MASK_CFG;
          `CCFG_OFS_STYLE: wmask = `CCFG_MASK_STYLE;
          default: wmask = 8'hff;
        endcase
      end
    end
  endfunction

  reg scl_q;
  reg sda_q;
  reg [3:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] ptr_q;
  reg rd_q;
  reg drive_q;
  reg wr_en_q;
  reg [7:0] wr_addr_q;
  reg [7:0] wr_data_q;
  wire [7:0] bank_w [0:`CCFG_BANK_SIZE-1];
  wire clk_sel;

  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_seen = scl_q & scl_in & sda_q & ~sda_in;
  wire stop_seen = scl_q & scl_in & ~sda_q & sda_in;
  // Pointers past the last byte read zero rather than aliasing the bank.
  wire [7:0] rd_byte = (ptr_q <= `CCFG_BANK_LAST) ? bank_w[ptr_q[4:0]] : 8'h00;

  // A start is honoured in any state, which also covers the repeated start of a read.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_q <= 1'b0;
      drive_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_en_q <= 1'b0;
      if (start_seen) begin
        state_q <= S_ADDR; // RL2 RL3
        cnt_q <= 4'h0;
        drive_q <= 1'b0;
      end else if (stop_seen) begin
        state_q <= S_IDLE; // RL6
        drive_q <= 1'b0;
      end else if (scl_rise) begin
        case (state_q)
          S_ADDR, S_PTR, S_WDATA: begin
            sh_q <= {sh_q[6:0], sda_in}; // RL5
            cnt_q <= cnt_q + 4'h1;
          end
          S_RDATA: begin
            cnt_q <= cnt_q + 4'h1;
          end
          S_RACK: begin
            if (sda_in) begin
              state_q <= S_IGNORE; // RL20
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_q)
          S_ADDR: begin
            if (cnt_q == 4'h8) begin
              if (sh_q[7:1] == {`CCFG_TARGET_ADDR_HI, addr_select}) begin // RL1
                drive_q <= 1'b1;
                rd_q <= sh_q[0];
                state_q <= S_AACK;
              end else begin
                state_q <= S_IGNORE; // RL19
              end
            end
          end
          S_AACK: begin
            cnt_q <= 4'h0;
            if (rd_q) begin
              sh_q <= rd_byte; // RL3
              drive_q <= ~rd_byte[7];
              state_q <= S_RDATA;
            end else begin
              drive_q <= 1'b0;
              state_q <= S_PTR; // RL4
            end
          end
          S_PTR: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= sh_q; // RL4
              drive_q <= 1'b1;
              state_q <= S_PACK;
            end
          end
          S_PACK, S_WACK: begin
            drive_q <= 1'b0;
            cnt_q <= 4'h0;
            state_q <= S_WDATA; // RL2
          end
          S_WDATA: begin
            if (cnt_q == 4'h8) begin
              wr_en_q <= 1'b1; // RL6
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
              ptr_q <= ptr_q + 8'h01; // RL5
              drive_q <= 1'b1;
              state_q <= S_WACK;
            end
          end
          S_RDATA: begin
            if (cnt_q == 4'h8) begin
              drive_q <= 1'b0;
              ptr_q <= ptr_q + 8'h01; // RL5
              state_q <= S_RACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0}; // RL5
              drive_q <= ~sh_q[6];
            end
          end
          S_RACK: begin
            cnt_q <= 4'h0;
            sh_q <= rd_byte;
            drive_q <= ~rd_byte[7];
            state_q <= S_RDATA;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Open-drain line: only a low is ever driven; the enable alone carries data.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~drive_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CCFG_BANK_SIZE; gi = gi + 1) begin : bank_g
      localparam [31:0] IDX_W = gi;
      localparam [7:0] IDX = IDX_W[7:0];
      localparam [7:0] DEF = def_byte(gi);
      localparam [7:0] MSK = wmask(gi);
      reg [7:0] byte_q;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          byte_q <= DEF; // RL15
        end else if (wr_en_q && (wr_addr_q == IDX)) begin
          byte_q <= wr_data_q & MSK; // RL13 RL14
        end
      end
      assign bank_w[gi] = byte_q;
    end
  endgenerate

  wire [4:0] base = {1'b0, freq_set_select, 2'b00}; // RL12
  wire [4:0] m_idx = base + 5'd`CCFG_OFS_M;
  wire [4:0] n_idx = base + 5'd`CCFG_OFS_N;
  wire [4:0] c_idx = base + 5'd`CCFG_OFS_CFG;
  wire [4:0] s_idx = base + 5'd`CCFG_OFS_STYLE;
  wire [4:0] o_idx = {3'b100, freq_set_select}; // RL12
  wire [7:0] n_byte = bank_w[n_idx];
  wire [7:0] c_byte = bank_w[c_idx];
  wire [7:0] s_byte = bank_w[s_idx];
  wire [7:0] o_byte = bank_w[o_idx];
  wire [8:0] fb_dec;
  wire [6:0] out_dec;
  wire [2:0] in_dec;
  wire [1:0] ps_dec;

  ccfg_div_decode u_dec (
    .clk_sel(clk_sel),
    .m_code(bank_w[m_idx]),
    .n_code(n_byte[7:1]),
    .p_code(c_byte[7:6]),
    .ps_code(c_byte[5:4]),
    .fb_div(fb_dec),
    .out_div(out_dec),
    .in_div(in_dec),
    .ps_mode(ps_dec)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_enable_bit <= 6'h00;
      output_style_bit <= 6'h00;
      pll_skip_bit <= 1'b0;
      feedback_divider <= 9'h000;
      output_divider <= 7'h00;
      input_divider <= 3'h0;
      input_prescaler_code <= 2'h0;
      charge_pump_range <= 2'h0;
    end else begin
      output_enable_bit <= {o_byte[7:5], o_byte[3:1]}; // RL16
      output_style_bit <= s_byte[5:0]; // RL17
      pll_skip_bit <= n_byte[0]; // RL18
      feedback_divider <= fb_dec; // RL8 RL13
      output_divider <= out_dec; // RL10
      input_divider <= in_dec; // RL9
      input_prescaler_code <= ps_dec; // RL9
      charge_pump_range <= c_byte[3:2];
    end
  end

  ccfg_ahb_regs u_ahb (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .stat_in({16'h0, ptr_q, 2'h0, freq_set_select, state_q}),
    .dec0_in({16'h0, feedback_divider, output_divider}),
    .dec1_in({8'h0, output_enable_bit, output_style_bit, 1'b0, pll_skip_bit, charge_pump_range,
              input_prescaler_code, input_divider, 3'h0}),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .clk_sel_q(clk_sel)
  );
endmodule
